// *** hw/flash_cmd_host.v ***
`timescale 1ns/10ps
`include "flash_cmd_defines.vh"
module flash_cmd_host #(
	parameter [7:0] CLK_DIV = 8'h0a,
	parameter ALT_OPTION = 0
) (
	input wire core_clk,
	input wire resetn,
	input wire cmd_valid,
	output reg cmd_ready,
	input wire [7:0] cmd_opcode,
	input wire [23:0] cmd_addr,
	input wire [15:0] cmd_len,
	output reg cmd_done,
	output reg cmd_err,
	output reg busy,
	input wire quad_io_permit,
	output reg four_line_command_entry,
	input wire [7:0] wr_data,
	input wire wr_valid,
	output reg wr_ready,
	output wire [7:0] rd_data,
	output wire rd_valid,
	input wire rd_ready,
	output reg sclk,
	output reg cs_n,
	input wire [3:0] io_in,
	output reg [3:0] io_out,
	output reg [3:0] io_oe_n
);
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_OPC = 7'h02;
	localparam [6:0] ST_ADDR = 7'h04;
	localparam [6:0] ST_DUMMY = 7'h08;
	localparam [6:0] ST_DATA = 7'h10;
	localparam [6:0] ST_GAP = 7'h20;
	localparam [6:0] ST_WAIT = 7'h40;
	localparam integer RESET_CYC_FULL = (`RESET_WAIT_NS +
		`CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS;
	localparam [11:0] RESET_CYC = RESET_CYC_FULL[11:0];
	localparam [7:0] CFG_FETCH = ALT_OPTION ? `OP_CONFIG_FETCH_ALT :
		`OP_CONFIG_FETCH_DEF;

	reg [6:0] state;
	reg [7:0] op;
	reg [1:0] dir;
	reg [2:0] aw;
	reg [2:0] dw;
	reg has_dummy;
	reg [1:0] addr_left;
	reg [23:0] addr;
	reg [15:0] data_left;
	reg [15:0] wr_left;
	reg [7:0] wbyte;
	reg wbyte_v;
	reg [7:0] sh;
	reg [3:0] bit_cnt;
	reg [2:0] lane;
	reg need_load;
	reg [7:0] div_cnt;
	reg [7:0] gap_cnt;
	reg [11:0] wait_cnt;
	reg [7:0] last_opc;
	reg [3:0] io_meta;
	reg [3:0] io_sync;

	// Decoder outputs
	reg d_ok;
	reg [1:0] d_addr;
	reg d_dummy;
	reg [1:0] d_dir;
	reg [15:0] d_cnt;
	reg [2:0] d_aw;
	reg [2:0] d_dw;

	wire [15:0] stream_cnt = (cmd_len == 16'h0000) ? `ONE_BYTE : cmd_len;
	wire [15:0] id_cnt = (stream_cnt > `ID_MAX_BYTES) ? `ID_MAX_BYTES :
		stream_cnt;
	wire buf_in_ready;
	wire rd_phase = (state == ST_DATA) && (dir == `DIR_RD);
	wire wr_phase = (state == ST_DATA) && (dir == `DIR_WR);
	wire shifting = (state == ST_OPC) || (state == ST_ADDR) ||
		(state == ST_DUMMY) || (state == ST_DATA);
	wire tick = shifting && !need_load && (div_cnt == CLK_DIV - 8'h01);
	wire can_load = !(wr_phase && !wbyte_v) && !(rd_phase && !buf_in_ready);
	wire [7:0] sh_next = (lane == `LANE_X4) ? {sh[3:0], io_sync} :
		(lane == `LANE_X2) ? {sh[5:0], io_sync[1:0]} :
		{sh[6:0], io_sync[1]};
	wire byte_end = tick && sclk && (bit_cnt == {1'b0, lane});
	wire [2:0] op_w = four_line_command_entry ? `LANE_X4 : `LANE_X1;
	wire [6:0] after_dummy = (data_left != 16'h0000) ? ST_DATA : ST_GAP;
	wire [6:0] after_addr = has_dummy ? ST_DUMMY : after_dummy;
	wire [6:0] after_opc = (addr_left != 2'h0) ? ST_ADDR : after_addr;

	// Pins seen by the host's own lanes for one shift step
	function [3:0] drive;
		input [7:0] b;
		input [2:0] w;
		begin
			if (w == `LANE_X4)
				drive = b[7:4];
			else if (w == `LANE_X2)
				drive = {2'b11, b[7:6]};
			else
				drive = {3'b111, b[7]};
		end
	endfunction

	// Enables, low means driven; idle lanes keep write protect and hold high
	function [3:0] enables;
		input rd;
		input [2:0] w;
		begin
			if (rd)
				enables = (w == `LANE_X4) ? 4'hf :
					(w == `LANE_X2) ? 4'h3 : 4'h2;
			else
				enables = (w == `LANE_X1) ? 4'h2 : 4'h0;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Opcode table: framing of each command
	always @* begin
		d_ok = 1'b1;
		d_addr = 2'h0;
		d_dummy = 1'b0;
		d_dir = `DIR_NONE;
		d_cnt = 16'h0000;
		d_aw = `LANE_X1;
		d_dw = `LANE_X1;
		case (cmd_opcode)
		`OP_FAST_ARRAY_FETCH, `OP_LOW_POWER_FETCH: begin
			d_addr = `ADDR_BYTES;
			d_dummy = (cmd_opcode == `OP_FAST_ARRAY_FETCH);
			d_dir = `DIR_RD;
			d_cnt = stream_cnt;
		end
		`OP_DUAL_OUTPUT_FETCH, `OP_TWO_LINE_IO_FETCH: begin
			d_addr = `ADDR_BYTES;
			d_dummy = 1'b1;
			d_dir = `DIR_RD;
			d_cnt = stream_cnt;
			d_dw = `LANE_X2;
			if (cmd_opcode == `OP_TWO_LINE_IO_FETCH)
				d_aw = `LANE_X2;
		end
		`OP_QUAD_OUTPUT_FETCH, `OP_FOUR_LINE_IO_FETCH,
		`OP_WORD_FOUR_LINE_FETCH, `OP_OCTAL_WORD_FETCH: begin
			d_addr = `ADDR_BYTES;
			d_dummy = 1'b1;
			d_dir = `DIR_RD;
			d_cnt = stream_cnt;
			d_dw = `LANE_X4;
			if (cmd_opcode != `OP_QUAD_OUTPUT_FETCH)
				d_aw = `LANE_X4;
		end
		`OP_PAGE_ERASE, `OP_FOUR_KIB_ERASE, `OP_HALF_BLOCK_ERASE,
		`OP_FULL_BLOCK_ERASE, `OP_SINGLE_BLOCK_LOCK,
		`OP_SINGLE_BLOCK_UNLOCK, `OP_SECURE_AREA_ERASE: begin
			d_addr = `ADDR_BYTES;
		end
		`OP_ARRAY_ERASE_A, `OP_ARRAY_ERASE_B, `OP_WRITE_LATCH_SET,
		`OP_WRITE_LATCH_CLEAR, `OP_VOLATILE_STATUS_PERMIT,
		`OP_ALL_BLOCKS_LOCK, `OP_ALL_BLOCKS_UNLOCK, `OP_DEEP_SLEEP_ENTRY,
		`OP_LEAVE_ENHANCED, `OP_RESET_ARM: begin
			d_ok = 1'b1;
		end
		`OP_PAGE_WRITE_SINGLE, `OP_PAGE_WRITE_DUAL, `OP_PAGE_WRITE_QUAD,
		`OP_SECURE_AREA_WRITE: begin
			d_addr = `ADDR_BYTES;
			d_dir = `DIR_WR;
			d_cnt = stream_cnt;
			if (cmd_opcode == `OP_PAGE_WRITE_DUAL)
				d_dw = `LANE_X2;
			if (cmd_opcode == `OP_PAGE_WRITE_QUAD)
				d_dw = `LANE_X4;
		end
		`OP_BLOCK_LOCK_QUERY_A, `OP_BLOCK_LOCK_QUERY_B,
		`OP_WAKE_AND_ID_FETCH: begin
			d_addr = `ADDR_BYTES;
			d_dir = `DIR_RD;
			d_cnt = `ONE_BYTE;
		end
		`OP_SECURE_AREA_FETCH: begin
			d_addr = `ADDR_BYTES;
			d_dummy = 1'b1;
			d_dir = `DIR_RD;
			d_cnt = stream_cnt;
		end
		`OP_STATUS0_FETCH, `OP_STATUS1_FETCH: begin
			d_dir = `DIR_RD;
			d_cnt = `ONE_BYTE;
		end
		`OP_BUSY_FLAG_NOTIFY: begin
			d_dummy = 1'b1;
		end
		`OP_STATUS_WRITE: begin
			d_dir = `DIR_WR;
			d_cnt = ALT_OPTION ? `TWO_BYTES : `ONE_BYTE;
		end
		`OP_STATUS1_WRITE, `OP_CONFIG_WRITE: begin
			d_ok = !(ALT_OPTION && cmd_opcode == `OP_STATUS1_WRITE);
			d_dir = `DIR_WR;
			d_cnt = `ONE_BYTE;
		end
		`OP_IDENTITY_FETCH: begin
			d_dir = `DIR_RD;
			d_cnt = id_cnt;
		end
		`OP_RESET_FIRE: begin
			d_ok = (last_opc == `OP_RESET_ARM);
		end
		`OP_FOUR_LINE_COMMAND_ENTRY: begin
			d_ok = quad_io_permit && !four_line_command_entry;
		end
		default: begin
			d_ok = (cmd_opcode == CFG_FETCH);
			d_dir = `DIR_RD;
			d_cnt = `ONE_BYTE;
		end
		endcase
		// Four-line entry carries every phase on four lanes
		if (four_line_command_entry) begin
			d_aw = `LANE_X4;
			d_dw = `LANE_X4;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser on the data lanes
	always @(posedge core_clk) begin
		if (!resetn) begin
			io_meta <= 4'h0;
			io_sync <= 4'h0;
		end else begin
			io_meta <= io_in;
			io_sync <= io_meta;
		end
	end

	// Clock divider, halted while a byte waits to be loaded
	always @(posedge core_clk) begin
		if (!resetn || !shifting || need_load || tick)
			div_cnt <= 8'h00;
		else
			div_cnt <= div_cnt + 8'h01;
	end

	// Write byte prefetch; the write data phase stalls only while no write byte is held
	always @(posedge core_clk) begin
		if (!resetn) begin
			wr_ready <= 1'b0;
			wbyte <= 8'h00;
			wbyte_v <= 1'b0;
			wr_left <= 16'h0000;
		end else begin
			wr_ready <= !wbyte_v && (wr_left != 16'h0000) &&
				!(wr_valid && wr_ready);
			if (state == ST_IDLE && cmd_valid && cmd_ready && d_ok &&
					d_dir == `DIR_WR)
				wr_left <= d_cnt;
			if (wr_valid && wr_ready) begin
				wbyte <= wr_data;
				wbyte_v <= 1'b1;
				wr_left <= wr_left - 16'h0001;
			end else if (need_load && can_load && wr_phase) begin
				wbyte_v <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command sequencer
	always @(posedge core_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			cmd_ready <= 1'b0;
			cmd_done <= 1'b0;
			cmd_err <= 1'b0;
			busy <= 1'b0;
			four_line_command_entry <= 1'b0;
			op <= 8'h00;
			dir <= `DIR_NONE;
			aw <= `LANE_X1;
			dw <= `LANE_X1;
			has_dummy <= 1'b0;
			addr_left <= 2'h0;
			addr <= 24'h000000;
			data_left <= 16'h0000;
			sh <= 8'h00;
			bit_cnt <= 4'h0;
			lane <= `LANE_X1;
			need_load <= 1'b0;
			gap_cnt <= 8'h00;
			wait_cnt <= 12'h000;
			last_opc <= 8'h00;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			io_out <= 4'hc;
			io_oe_n <= 4'h3;
		end else begin
			cmd_done <= 1'b0;
			cmd_err <= 1'b0;
			busy <= (state != ST_IDLE);
			case (state)
			ST_IDLE: begin
				cmd_ready <= !(cmd_valid && cmd_ready);
				if (cmd_valid && cmd_ready) begin
					if (!d_ok) begin
						cmd_err <= 1'b1;
					end else begin
						op <= cmd_opcode;
						dir <= d_dir;
						aw <= d_aw;
						dw <= d_dw;
						has_dummy <= d_dummy;
						addr_left <= d_addr;
						addr <= cmd_addr;
						data_left <= d_cnt;
						cs_n <= 1'b0;
						need_load <= 1'b1;
						busy <= 1'b1;
						state <= ST_OPC;
					end
				end
			end
			ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA: begin
				if (need_load && can_load) begin
					need_load <= 1'b0;
					bit_cnt <= `BYTE_BITS;
					if (state == ST_OPC) begin
						sh <= op;
						lane <= op_w;
						io_out <= drive(op, op_w);
						io_oe_n <= enables(1'b0, op_w);
					end else if (state == ST_ADDR) begin
						sh <= addr[23:16];
						lane <= aw;
						addr <= {addr[15:0], 8'h00};
						io_out <= drive(addr[23:16], aw);
						io_oe_n <= enables(1'b0, aw);
					end else if (state == ST_DUMMY) begin
						// Zero mode bits keep continuous read off
						sh <= 8'h00;
						lane <= aw;
						io_out <= drive(8'h00, aw);
						io_oe_n <= enables(1'b0, aw);
					end else begin
						sh <= wr_phase ? wbyte : 8'h00;
						lane <= dw;
						io_out <= drive(wbyte, dw);
						io_oe_n <= enables(rd_phase, dw);
					end
				end else if (tick && !sclk) begin
					sclk <= 1'b1;
				end else if (tick) begin
					// Falling edge: sample, then present the next bits
					sclk <= 1'b0;
					sh <= sh_next;
					if (!byte_end) begin
						bit_cnt <= bit_cnt - {1'b0, lane};
						io_out <= drive(sh_next, lane);
					end else begin
						need_load <= 1'b1;
						if (state == ST_OPC) begin
							state <= after_opc;
						end else if (state == ST_ADDR) begin
							addr_left <= addr_left - 2'h1;
							if (addr_left == 2'h1)
								state <= after_addr;
						end else if (state == ST_DUMMY) begin
							state <= after_dummy;
						end else begin
							// Device steps its address; stream ends here
							data_left <= data_left - 16'h0001;
							if (data_left == 16'h0001)
								state <= ST_GAP;
						end
					end
				end
			end
			ST_GAP: begin
				// Select rises only after a whole byte
				cs_n <= 1'b1;
				need_load <= 1'b0;
				io_out <= 4'hc;
				io_oe_n <= 4'h3;
				gap_cnt <= gap_cnt + 8'h01;
				if (gap_cnt == `CS_GAP_CYCLES) begin
					gap_cnt <= 8'h00;
					last_opc <= op;
					if (op == `OP_FOUR_LINE_COMMAND_ENTRY)
						four_line_command_entry <= 1'b1;
					if (op == `OP_LEAVE_ENHANCED ||
							op == `OP_RESET_FIRE)
						four_line_command_entry <= 1'b0;
					if (op == `OP_RESET_FIRE) begin
						state <= ST_WAIT;
					end else begin
						cmd_done <= 1'b1;
						state <= ST_IDLE;
					end
				end
			end
			ST_WAIT: begin
				// No command goes out while the device resets
				wait_cnt <= wait_cnt + 12'h001;
				if (wait_cnt == RESET_CYC - 12'h001) begin
					wait_cnt <= 12'h000;
					cmd_done <= 1'b1;
					state <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read bytes pass a two-entry buffer; SCLK stops while it is full
	two_entry_buffer #(
		.WIDTH(8)
	) u_rd_buffer (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_data(sh_next),
		.in_valid(byte_end && rd_phase),
		.in_ready(buf_in_ready),
		.out_data(rd_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready)
	);
endmodule

// *** shared/flash_cmd_defines.vh ***
// Operation
// - 0Bh fast read, 03h plain read, stream
// - 3Bh read, data two bits per clock
// - BBh read, address and data on two lines
// - 6Bh read, data four bits per clock
// - EBh read, address and data on four lines
// - E7h word read on four lines
// - E3h octal word read on four lines
// - 81h, 20h, 52h erase with address
// - D8h block erase; 60h/C7h whole erase
// - 02h, A2h, 32h program, address plus data
// - 36h/39h lock/unlock, 3Ch/3Dh query block
// - 44h erase, 42h write, 48h read secure
// - 05h and 35h return one status byte
// - Config read 15h default, 45h alternate
// - 25h sends one dummy byte only
// - 01h one or two bytes; 31h default only
// - 9Fh returns one to three id bytes
// - 66h then 99h resets; 30 us wait
// - Chip select rises on byte boundary
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH
`define OP_FAST_ARRAY_FETCH 8'h0b
`define OP_LOW_POWER_FETCH 8'h03
`define OP_DUAL_OUTPUT_FETCH 8'h3b
`define OP_TWO_LINE_IO_FETCH 8'hbb
`define OP_QUAD_OUTPUT_FETCH 8'h6b
`define OP_FOUR_LINE_IO_FETCH 8'heb
`define OP_WORD_FOUR_LINE_FETCH 8'he7
`define OP_OCTAL_WORD_FETCH 8'he3
`define OP_PAGE_ERASE 8'h81
`define OP_FOUR_KIB_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_FULL_BLOCK_ERASE 8'hd8
`define OP_ARRAY_ERASE_A 8'h60
`define OP_ARRAY_ERASE_B 8'hc7
`define OP_PAGE_WRITE_SINGLE 8'h02
`define OP_PAGE_WRITE_DUAL 8'ha2
`define OP_PAGE_WRITE_QUAD 8'h32
`define OP_WRITE_LATCH_SET 8'h06
`define OP_WRITE_LATCH_CLEAR 8'h04
`define OP_VOLATILE_STATUS_PERMIT 8'h50
`define OP_SINGLE_BLOCK_LOCK 8'h36
`define OP_SINGLE_BLOCK_UNLOCK 8'h39
`define OP_BLOCK_LOCK_QUERY_A 8'h3c
`define OP_BLOCK_LOCK_QUERY_B 8'h3d
`define OP_ALL_BLOCKS_LOCK 8'h7e
`define OP_ALL_BLOCKS_UNLOCK 8'h98
`define OP_SECURE_AREA_ERASE 8'h44
`define OP_SECURE_AREA_WRITE 8'h42
`define OP_SECURE_AREA_FETCH 8'h48
`define OP_STATUS0_FETCH 8'h05
`define OP_STATUS1_FETCH 8'h35
`define OP_CONFIG_FETCH_DEF 8'h15
`define OP_CONFIG_FETCH_ALT 8'h45
`define OP_CONFIG_WRITE 8'h11
`define OP_BUSY_FLAG_NOTIFY 8'h25
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS1_WRITE 8'h31
`define OP_IDENTITY_FETCH 8'h9f
`define OP_DEEP_SLEEP_ENTRY 8'hb9
`define OP_WAKE_AND_ID_FETCH 8'hab
`define OP_LEAVE_ENHANCED 8'hff
`define OP_RESET_ARM 8'h66
`define OP_RESET_FIRE 8'h99
`define OP_FOUR_LINE_COMMAND_ENTRY 8'h38
`define LANE_X1 3'h1
`define LANE_X2 3'h2
`define LANE_X4 3'h4
`define DIR_NONE 2'h0
`define DIR_RD 2'h1
`define DIR_WR 2'h2
`define ADDR_BYTES 2'h3
`define BYTE_BITS 4'h8
`define ONE_BYTE 16'h0001
`define TWO_BYTES 16'h0002
`define ID_MAX_BYTES 16'h0003
`define RESET_WAIT_NS 30000
`define CORE_PERIOD_NS 8
`define CS_GAP_CYCLES 8'h04
`endif

// *** hw/two_entry_buffer.v ***
`timescale 1ns/10ps
module two_entry_buffer #(
	parameter WIDTH = 8
) (
	input wire core_clk,
	input wire resetn,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output reg [WIDTH-1:0] out_data,
	output reg out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] tail_data;
	reg tail_valid;
	wire pop = out_valid & out_ready;
	wire push = in_valid & ~tail_valid;

	// Ready only depends on the tail slot, so no path from out_ready
	assign in_ready = ~tail_valid;

	// Head always holds the oldest word; tail moves up on a pop
	always @(posedge core_clk) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			tail_valid <= 1'b0;
			out_data <= {WIDTH{1'b0}};
			tail_data <= {WIDTH{1'b0}};
		end else if (pop) begin
			if (tail_valid) begin
				out_data <= tail_data;
				tail_valid <= push;
				tail_data <= in_data;
			end else begin
				out_valid <= push;
				out_data <= in_data;
			end
		end else if (push) begin
			if (!out_valid) begin
				out_valid <= 1'b1;
				out_data <= in_data;
			end else begin
				tail_valid <= 1'b1;
				tail_data <= in_data;
			end
		end
	end
endmodule

// *** bench/flash_cmd_host_asserts.sv ***
`timescale 1ns/10ps
module flash_cmd_host_asserts #(
	parameter [7:0] CLK_DIV = 8'h0a,
	parameter ALT_OPTION = 0
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_opcode,
	input wire logic cmd_done,
	input wire logic cmd_err,
	input wire logic busy,
	input wire logic quad_io_permit,
	input wire logic four_line_command_entry,
	input wire logic sclk,
	input wire logic cs_n
);
	localparam int RST_WAIT = 3750;
	logic take;
	logic [7:0] last_op;
	logic [15:0] since;
	assign take = cmd_valid && cmd_ready;
	////////////////////////////////////////////////////////////////////////
	// Age of the last accepted command, saturating so it never wraps
	always @(posedge core_clk) begin
		if (!resetn) begin
			last_op <= 8'h00;
			since <= 16'h0000;
		end else if (take) begin
			last_op <= cmd_opcode;
			since <= 16'h0000;
		end else if (since != 16'hffff) begin
			since <= since + 16'h0001;
		end
	end
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////
	AST_CS_BUSY: assert property (!cs_n |-> busy)
		else $error("select low while idle");
	AST_CS_BOUNDARY: assert property ($rose(cs_n) |-> !sclk && !$past(sclk))
		else $error("select rose with clock high");
	AST_DONE_GAP: assert property (cmd_done |-> cs_n && $past(cs_n, 4))
		else $error("done without select gap");
	AST_UNKNOWN_REFUSED: assert property (take && cmd_opcode == 8'hf0 |=> cmd_err && cs_n)
		else $error("unknown opcode not refused");
	AST_ERR_PULSE: assert property (cmd_err |-> !cmd_ready ##1 !cmd_err)
		else $error("refusal pulse too long");
	AST_CFG_OPTION: assert property (take && cmd_opcode == 8'h45 && ALT_OPTION == 0 |=> cmd_err)
		else $error("config alias accepted");
	AST_CFG_DEFAULT: assert property (take && cmd_opcode == 8'h15 && ALT_OPTION == 0 |=> !cmd_err)
		else $error("config read refused");
	AST_QUAD_GATE: assert property (take && cmd_opcode == 8'h38 && !quad_io_permit |=> cmd_err)
		else $error("four-line entry without permit");
	AST_QUAD_ENTER: assert property (take && cmd_opcode == 8'h38 && quad_io_permit && !four_line_command_entry |-> ##[1:600] four_line_command_entry)
		else $error("four-line entry not taken");
	AST_RESET_WAIT: assert property (cmd_done && last_op == 8'h99 |-> since >= RST_WAIT)
		else $error("reset wait too short");
	// Main scenarios
	COV_RESET: cover property (cmd_done && last_op == 8'h99);
	COV_QUAD: cover property ($rose(four_line_command_entry));
	COV_REFUSE: cover property (cmd_err);
endmodule
bind flash_cmd_host flash_cmd_host_asserts #(.CLK_DIV(CLK_DIV), .ALT_OPTION(ALT_OPTION)) u_chk (.core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_done(cmd_done), .cmd_err(cmd_err), .busy(busy), .quad_io_permit(quad_io_permit), .four_line_command_entry(four_line_command_entry), .sclk(sclk), .cs_n(cs_n));

// *** bench/flash_dev_model.sv ***
`timescale 1ns/10ps
module flash_dev_model (
	input wire sclk,
	input wire cs_n,
	input wire [3:0] io,
	output reg [3:0] dev_out,
	output reg [3:0] dev_oe_n,
	output reg [7:0] last_op,
	output reg [15:0] last_edges,
	output reg [7:0] wr_byte,
	output reg qpi
);
	reg [7:0] op;
	reg [7:0] sh;
	reg wel, vperm, locked, asleep;
	integer ecnt, hdr, lanes, p, whdr;
	initial begin
		{qpi, wel, vperm, locked, asleep} = 5'h00;
		dev_oe_n = 4'hf;
		dev_out = 4'h0;
		wr_byte = 8'h00;
		op = 8'h00;
		ecnt = 0;
	end
	////////////////////////////////////////////////////////////////////////
	// A falling select starts a fresh decode
	always @(negedge cs_n) begin
		ecnt = 0;
		op = 8'h00;
	end
	// Opcode capture, four lanes in four-line entry
	always @(posedge sclk) begin
		if (!cs_n && qpi && ecnt < 2)
			op = {op[3:0], io};
		else if (!cs_n && !qpi && ecnt < 8)
			op = {op[6:0], io[0]};
		// First single-lane write byte, kept for the data check
		whdr = (op == 8'h02 || op == 8'h42) ? 32 :
			(op == 8'h01 || op == 8'h31) ? 8 : 1000;
		if (!cs_n && !qpi && ecnt >= whdr && ecnt < whdr + 8)
			wr_byte = {wr_byte[6:0], io[0]};
		ecnt = ecnt + 1;
	end
	// Shift out on the falling clock once the header is past
	always @(negedge sclk) begin
		case (op)
		8'h03, 8'hab, 8'h3c, 8'h3d: begin hdr = 32; lanes = 1; end
		8'h0b, 8'h48: begin hdr = 40; lanes = 1; end
		8'h3b: begin hdr = 40; lanes = 2; end
		8'hbb: begin hdr = 24; lanes = 2; end
		8'h6b: begin hdr = 40; lanes = 4; end
		8'heb, 8'he7, 8'he3: begin hdr = 16; lanes = 4; end
		8'h05, 8'h35, 8'h15, 8'h9f: begin hdr = 8; lanes = 1; end
		default: begin hdr = 0; lanes = 0; end
		endcase
		// Byte value follows the advancing address
		p = (ecnt - hdr) * lanes;
		sh = (8'ha0 + p / 8) << (p % 8);
		dev_oe_n = 4'hf;
		if (!cs_n && !qpi && lanes != 0 && ecnt >= hdr) begin
			dev_oe_n = (lanes == 1) ? 4'hd : (lanes == 2) ? 4'hc : 4'h0;
			dev_out = (lanes == 4) ? sh[7:4] :
				(lanes == 2) ? {2'b00, sh[7:6]} : {2'b00, sh[7], 1'b0};
		end
	end
	// Opcode-only commands act only when select rises right after the opcode byte; ABh wakes on any rise
	always @(posedge cs_n) begin
		dev_oe_n = 4'hf;
		last_op = op;
		last_edges = ecnt[15:0];
		if (ecnt == 8 || (qpi && ecnt == 2)) begin
			case (op)
			8'h06: wel = 1'b1;
			8'h04: wel = 1'b0;
			8'h50: vperm = 1'b1;
			8'h7e: locked = 1'b1;
			8'h98: locked = 1'b0;
			8'hb9: asleep = 1'b1;
			8'h38: qpi = 1'b1;
			8'hff, 8'h99: qpi = 1'b0;
			default: ;
			endcase
		end
		if (op == 8'hab)
			asleep = 1'b0;
	end
endmodule

// *** bench/serial_flash_opcode_decoder_tb.sv ***
`timescale 1ns/10ps
module serial_flash_opcode_decoder_tb;
	reg core_clk, resetn, cmd_valid, quad_io_permit, wr_valid, rd_ready, tog;
	reg [7:0] cmd_opcode, wr_data;
	reg [23:0] cmd_addr;
	reg [15:0] cmd_len;
	reg [7:0] rd_q [0:15];
	wire cmd_ready, cmd_done, cmd_err, busy, four_line_command_entry;
	wire wr_ready, rd_valid, sclk, cs_n, dev_qpi;
	wire [7:0] rd_data, dev_op, dev_wr;
	wire [15:0] dev_edges;
	wire [3:0] io_in, io_out, io_oe_n, dev_out, dev_oe_n;
	integer err_total, check_count, lat, cyc, rd_n, wr_req, wr_taken;
	flash_cmd_host #(.CLK_DIV(8'h0a), .ALT_OPTION(0)) dut (
		.core_clk(core_clk), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .cmd_done(cmd_done), .cmd_err(cmd_err), .busy(busy),
		.quad_io_permit(quad_io_permit),
		.four_line_command_entry(four_line_command_entry),
		.wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n));
	flash_dev_model u_dev (.sclk(sclk), .cs_n(cs_n), .io(io_in),
		.dev_out(dev_out), .dev_oe_n(dev_oe_n), .last_op(dev_op),
		.last_edges(dev_edges), .wr_byte(dev_wr), .qpi(dev_qpi));
	// Undriven lanes toggle so a stale value never looks valid
	assign io_in = (~io_oe_n & io_out) | (io_oe_n & ~dev_oe_n & dev_out) |
		(io_oe_n & dev_oe_n & {4{tog}});
	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// Exact-count producer; sink is slow so the buffer fills and stalls
	always @(posedge core_clk) begin
		tog <= ~tog;
		cyc <= cyc + 1;
		if (wr_valid && wr_ready) begin
			wr_taken <= wr_taken + 1;
			wr_data <= wr_data + 8'h01;
		end
		wr_valid <= (wr_taken + (wr_valid && wr_ready)) < wr_req;
		rd_ready <= (cyc % 97) == 0;
		if (rd_valid && rd_ready) begin
			rd_q[rd_n % 16] <= rd_data;
			rd_n <= rd_n + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input [31:0] e, input [31:0] g);
		begin
			check_count = check_count + 1;
			if (e !== g) begin
				err_total = err_total + 1;
				$display("mismatch %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, err_total);
			if (err_total == 0 && check_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// One command: supply nw bytes, expect ed link edges and nr read bytes
	task automatic c(input [7:0] op, input integer len, nw, ed, nr, bad);
		integer t, k, base;
		reg [7:0] first;
		begin
			base = rd_n;
			first = wr_data;
			wr_req <= wr_taken + nw;
			cmd_opcode <= op;
			cmd_addr <= 24'h012345;
			cmd_len <= len;
			cmd_valid <= 1'b1;
			t = 0;
			do begin @(posedge core_clk); t = t + 1; end
			while (cmd_ready !== 1'b1 && t < 9000);
			cmd_valid <= 1'b0;
			lat = 0;
			do begin @(posedge core_clk); lat = lat + 1; end
			while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && lat < 9000);
			chk("outcome", bad ? 2'b10 : 2'b01, {cmd_err, cmd_done});
			if (!bad) begin
				chk("edges", ed, dev_edges);
				chk("opcode", op, dev_op);
				chk("wr_taken", wr_req, wr_taken);
				if (nw > 0 && op != 8'ha2 && op != 8'h32)
					chk("wr_byte", first, dev_wr);
			end
			t = 0;
			while (rd_n < base + nr && t < 3000) begin
				@(posedge core_clk);
				t = t + 1;
			end
			for (k = 0; k < nr; k = k + 1)
				chk("rd_data", 8'ha0 + k, rd_q[(base + k) % 16]);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, cmd_valid, quad_io_permit, wr_valid, rd_ready, tog} = 6'h00;
		{cmd_opcode, wr_data, cmd_addr, cmd_len} = 56'h0;
		{err_total, check_count, lat, cyc, rd_n, wr_req, wr_taken} = 0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		c(8'h03, 2, 0, 48, 2, 0);
		c(8'h0b, 2, 0, 56, 2, 0);
		c(8'h0b, 6, 0, 88, 6, 0);
		c(8'h3b, 2, 0, 48, 2, 0);
		c(8'hbb, 2, 0, 32, 2, 0);
		c(8'h6b, 2, 0, 44, 2, 0);
		c(8'heb, 6, 0, 28, 6, 0);
		c(8'he7, 2, 0, 20, 2, 0);
		c(8'he3, 2, 0, 20, 2, 0);
		c(8'h81, 0, 0, 32, 0, 0);
		c(8'h20, 0, 0, 32, 0, 0);
		c(8'h52, 0, 0, 32, 0, 0);
		c(8'hd8, 0, 0, 32, 0, 0);
		c(8'h60, 0, 0, 8, 0, 0);
		c(8'hc7, 0, 0, 8, 0, 0);
		c(8'h02, 2, 2, 48, 0, 0);
		c(8'ha2, 2, 2, 40, 0, 0);
		c(8'h32, 2, 2, 36, 0, 0);
		c(8'h06, 0, 0, 8, 0, 0);
		c(8'h04, 0, 0, 8, 0, 0);
		c(8'h50, 0, 0, 8, 0, 0);
		c(8'h36, 0, 0, 32, 0, 0);
		c(8'h39, 0, 0, 32, 0, 0);
		c(8'h3c, 1, 0, 40, 1, 0);
		c(8'h3d, 1, 0, 40, 1, 0);
		c(8'h7e, 0, 0, 8, 0, 0);
		c(8'h98, 0, 0, 8, 0, 0);
		c(8'h44, 0, 0, 32, 0, 0);
		c(8'h42, 1, 1, 40, 0, 0);
		c(8'h48, 2, 0, 56, 2, 0);
		c(8'h05, 1, 0, 16, 1, 0);
		c(8'h35, 1, 0, 16, 1, 0);
		c(8'h15, 1, 0, 16, 1, 0);
		c(8'h45, 1, 0, 0, 0, 1);
		c(8'h25, 0, 0, 16, 0, 0);
		c(8'h01, 1, 1, 16, 0, 0);
		c(8'h31, 1, 1, 16, 0, 0);
		c(8'h9f, 5, 0, 32, 3, 0);
		c(8'hb9, 0, 0, 8, 0, 0);
		c(8'hab, 1, 0, 40, 1, 0);
		c(8'hff, 0, 0, 8, 0, 0);
		c(8'hf0, 0, 0, 0, 0, 1);
		c(8'h99, 0, 0, 0, 0, 1);
		c(8'h66, 0, 0, 8, 0, 0);
		c(8'h06, 0, 0, 8, 0, 0);
		c(8'h99, 0, 0, 0, 0, 1);
		c(8'h66, 0, 0, 8, 0, 0);
		c(8'h99, 0, 0, 8, 0, 0);
		chk("reset_wait", 1, lat >= 3910);
		c(8'h38, 0, 0, 0, 0, 1);
		quad_io_permit <= 1'b1;
		c(8'h38, 0, 0, 8, 0, 0);
		chk("four_line", 1, {four_line_command_entry, dev_qpi} === 2'b11);
		c(8'h06, 0, 0, 2, 0, 0);
		c(8'hff, 0, 0, 2, 0, 0);
		chk("four_line", 1, {four_line_command_entry, dev_qpi} === 2'b00);
		print_verdict;
	end
	// Run should end near 30k cycles; this cuts a hang short at 60k
	initial begin
		#480000;
		err_total = err_total + 1;
		print_verdict;
	end
endmodule
